// ### design/prs_pkg.sv
// shared constants for the power-up / hardware-reset sequencing pair
// assumes a single 40 MHz system clock on both ends
package prs_pkg;
    // clock period in ns
    localparam int CLK_PERIOD_NS = 25;
    // self-initialization wait, microseconds (longest: device counts it up)
    localparam int INIT_WAIT_TIME_US = 150;
    // least reset pulse, ns
    localparam int RESET_PULSE_MIN_NS = 200;
    // least reset high to select, ns
    localparam int RESET_HIGH_TO_SELECT_NS = 200;
    // least reset low to select, ns
    localparam int RESET_LOW_TO_SELECT_NS = 400;
    // least supply-off duration for a clean power-on, microseconds
    localparam int SUPPLY_OFF_DURATION_US = 50;
    // cycle counts; least times round up, the device wait rounds down
    localparam int INIT_WAIT_CYC = (INIT_WAIT_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_HIGH_CYC =
        (RESET_HIGH_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_LOW_CYC = (RESET_LOW_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUPPLY_OFF_CYC =
        (SUPPLY_OFF_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // device configuration register default
    localparam logic [15:0] CFG_RESET_VALUE = 16'h8f1f;
    // refresh row counter default and width
    localparam int ROW_W = 13;
    localparam logic [12:0] ROW_RESET_VALUE = 13'h0000;
    // device operating states
    typedef enum logic [2:0] {
        PRS_ST_POWER_OFF = 3'b000,
        PRS_ST_RESET = 3'b001,
        PRS_ST_INIT = 3'b010,
        PRS_ST_STANDBY = 3'b011,
        PRS_ST_HYBRID_SLEEP = 3'b100,
        PRS_ST_DEEP_POWER_DOWN = 3'b101
    } prs_state_e;
endpackage

// ### design/prs_link_if.sv
// pin-level link between host controller and memory device
// both ends on clk_sys; device samples pins through its own synchronisers
`timescale 1ns/100ps
`default_nettype none
interface prs_link_if;
    // chip select, active low, driven by host
    logic cs_n;
    // hardware reset pin, active low, driven by host
    logic hw_reset_n;
    // device side
    modport device (input cs_n, input hw_reset_n);
    // host side
    modport host (output cs_n, output hw_reset_n);
endinterface
`default_nettype wire

// ### design/prs_device.sv
// device end: power-up self-initialization, supply-dip and hardware reset handling
// assumes pins arrive asynchronously; supply monitor levels are plain inputs
// Summary of operation
// RULE1 - up to 150 us self-init before first access
// RULE2 - host keeps select high during power-up
// RULE3 - reset low postpones self-init start
// RULE4 - host issues no transfers during self-init
// RULE5 - self-init refreshes array, then device ready
// RULE6 - short supply dip needs host hardware reset
// RULE7 - reset pin returns device to standby
// RULE8 - reset low at least 200 ns, bus idle
// RULE9 - select waits 200 ns after reset high
// RULE10 - select waits 400 ns after reset fall
// RULE11 - hardware reset restores configuration defaults
// RULE12 - reset low halts refresh, array invalid
// RULE13 - refresh resumes when reset returns high
// RULE14 - reset restores refresh row counter default
// RULE15 - reset exits hybrid sleep and deep power-down
// RULE16 - host treats array as lost after reset
// RULE17 - host counts intervals from its clock, rounding up
`timescale 1ns/100ps
`default_nettype none
module prs_device #(
    parameter int INIT_CYCLES = prs_pkg::INIT_WAIT_CYC,
    parameter int ROW_COUNT = 8192
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // link pins
    prs_link_if.device link,
    // supply monitor: at or above minimum, above lockout level
    input wire logic supply_ok,
    input wire logic supply_above_lockout,
    // low-power requests and configuration writes from the device's command path
    input wire logic sleep_req,
    input wire logic dpd_req,
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wdata,
    // status
    output logic ready,
    output logic refresh_active,
    output logic array_valid,
    output logic [2:0] state,
    output logic [15:0] cfg,
    output logic [prs_pkg::ROW_W-1:0] refresh_row,
    output logic access_violation
);
    // elaboration checks
    initial
    begin
        if (INIT_CYCLES < 1 || INIT_CYCLES > 2**24 - 1)
            $error("prs_device: INIT_CYCLES out of range");
        if (ROW_COUNT < 2 || ROW_COUNT > 2**prs_pkg::ROW_W)
            $error("prs_device: ROW_COUNT out of range");
    end

    // pin synchronisers, two flops each
    logic [1:0] rst_sync_q;
    logic [1:0] cs_sync_q;
    logic [1:0] sup_sync_q;
    logic [1:0] lko_sync_q;
    // state and counters
    prs_pkg::prs_state_e state_q, state_d;
    logic [23:0] init_cnt_q;
    logic [prs_pkg::ROW_W-1:0] row_q;
    logic [15:0] cfg_q;
    logic array_valid_q;
    // set by a finished power-on init and kept through hardware resets, since the
    // reset itself clears array validity and cannot tell standby from a fresh power-on
    logic inited_q;
    logic viol_q;

    // synchronised levels, read only from the second flop
    wire pin_reset_n = rst_sync_q[1];
    wire pin_cs_n = cs_sync_q[1];
    wire sup_ok = sup_sync_q[1];
    wire sup_lko = lko_sync_q[1];
    // dip below lockout loses everything and forces a new power-on
    wire power_lost = !sup_lko;
    wire init_done = (init_cnt_q == 24'(INIT_CYCLES - 1));
    wire row_wrap = (row_q == prs_pkg::ROW_W'(ROW_COUNT - 1));
    // refresh runs only when powered, out of reset and not in deep power-down
    wire refresh_on = (state_q == prs_pkg::PRS_ST_INIT) ||
        (state_q == prs_pkg::PRS_ST_STANDBY) || (state_q == prs_pkg::PRS_ST_HYBRID_SLEEP);
    // selection while not ready is a host-side breach, flagged for visibility
    wire bad_select = !pin_cs_n && (state_q != prs_pkg::PRS_ST_STANDBY);

    // pin capture
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rst_sync_q <= 2'h0;
            cs_sync_q <= 2'h3;
            sup_sync_q <= 2'h0;
            lko_sync_q <= 2'h0;
        end
        else if (clk_en)
        begin
            rst_sync_q <= {rst_sync_q[0], link.hw_reset_n};
            cs_sync_q <= {cs_sync_q[0], link.cs_n};
            sup_sync_q <= {sup_sync_q[0], supply_ok};
            lko_sync_q <= {lko_sync_q[0], supply_above_lockout};
        end
    end

    // next-state selection
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            prs_pkg::PRS_ST_POWER_OFF:
                // wait for supply, and for reset pin high
                if (sup_ok && pin_reset_n)
                    state_d = prs_pkg::PRS_ST_INIT; // RULE3
                else if (sup_ok)
                    state_d = prs_pkg::PRS_ST_RESET;
            prs_pkg::PRS_ST_RESET:
                // reset release starts init after power-on, else goes straight to standby
                if (pin_reset_n)
                    state_d = inited_q ? prs_pkg::PRS_ST_STANDBY
                                       : prs_pkg::PRS_ST_INIT; // RULE3 RULE7
            prs_pkg::PRS_ST_INIT:
                if (init_done)
                    state_d = prs_pkg::PRS_ST_STANDBY; // RULE1 RULE5
            prs_pkg::PRS_ST_STANDBY:
                if (dpd_req)
                    state_d = prs_pkg::PRS_ST_DEEP_POWER_DOWN;
                else if (sleep_req)
                    state_d = prs_pkg::PRS_ST_HYBRID_SLEEP;
            prs_pkg::PRS_ST_HYBRID_SLEEP: state_d = state_q;
            prs_pkg::PRS_ST_DEEP_POWER_DOWN: state_d = state_q;
            default: state_d = prs_pkg::PRS_ST_POWER_OFF;
        endcase
        // reset pin overrides every powered state, sleep and dpd included
        if (!pin_reset_n && sup_ok && state_q != prs_pkg::PRS_ST_POWER_OFF)
            state_d = prs_pkg::PRS_ST_RESET; // RULE7 RULE15
        if (power_lost)
            state_d = prs_pkg::PRS_ST_POWER_OFF;
    end

    // state register and init counter
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q <= prs_pkg::PRS_ST_POWER_OFF;
            init_cnt_q <= 24'h000000;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            // counter only runs inside init
            if (state_q == prs_pkg::PRS_ST_INIT && !init_done)
                init_cnt_q <= init_cnt_q + 24'h000001; // RULE1
            else if (state_q != prs_pkg::PRS_ST_INIT)
                init_cnt_q <= 24'h000000;
        end
    end

    // configuration register, refresh row and array validity
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cfg_q <= prs_pkg::CFG_RESET_VALUE;
            row_q <= prs_pkg::ROW_RESET_VALUE;
            array_valid_q <= 1'b0;
            viol_q <= 1'b0;
            inited_q <= 1'b0;
        end
        else if (clk_en)
        begin
            viol_q <= bad_select;
            // only a real power loss forces the long init wait again
            if (state_q == prs_pkg::PRS_ST_POWER_OFF)
                inited_q <= 1'b0;
            else if (state_q == prs_pkg::PRS_ST_INIT && init_done)
                inited_q <= 1'b1; // RULE7
            if (state_q == prs_pkg::PRS_ST_RESET || state_q == prs_pkg::PRS_ST_POWER_OFF)
            begin
                cfg_q <= prs_pkg::CFG_RESET_VALUE; // RULE11
                row_q <= prs_pkg::ROW_RESET_VALUE; // RULE14
                array_valid_q <= 1'b0; // RULE12
            end
            else
            begin
                if (cfg_wr && state_q == prs_pkg::PRS_ST_STANDBY)
                    cfg_q <= cfg_wdata;
                // refresh walks the rows again after reset release
                if (refresh_on)
                    row_q <= row_wrap ? prs_pkg::ROW_RESET_VALUE
                                      : row_q + prs_pkg::ROW_W'(1); // RULE13
                // array counts as initialized once init ends
                if (state_q == prs_pkg::PRS_ST_INIT && init_done)
                    array_valid_q <= 1'b1; // RULE5
            end
        end
    end

    // registered status outputs
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ready <= 1'b0;
            refresh_active <= 1'b0;
            array_valid <= 1'b0;
            state <= 3'h0;
            cfg <= prs_pkg::CFG_RESET_VALUE;
            refresh_row <= prs_pkg::ROW_RESET_VALUE;
            access_violation <= 1'b0;
        end
        else if (clk_en)
        begin
            ready <= (state_q == prs_pkg::PRS_ST_STANDBY);
            refresh_active <= refresh_on; // RULE12 RULE13
            array_valid <= array_valid_q;
            state <= state_q;
            cfg <= cfg_q;
            refresh_row <= row_q;
            access_violation <= viol_q;
        end
    end
endmodule
`default_nettype wire

// ### design/prs_host.sv
// host end: drives the reset pin and chip select with the required spacing
// assumes power-up of the device and host coincide with rst_n release
`timescale 1ns/100ps
`default_nettype none
module prs_host #(
    parameter int INIT_CYCLES = prs_pkg::INIT_WAIT_CYC,
    parameter int PULSE_CYCLES = prs_pkg::RESET_PULSE_CYC
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // link pins
    prs_link_if.host link,
    // user requests
    input wire logic hw_reset_req,
    input wire logic select_req,
    // status
    output logic link_ready,
    output logic data_lost,
    output logic busy
);
    initial
    begin
        if (INIT_CYCLES < 1 || INIT_CYCLES > 2**24 - 1)
            $error("prs_host: INIT_CYCLES out of range");
        if (PULSE_CYCLES < prs_pkg::RESET_PULSE_CYC)
            $error("prs_host: PULSE_CYCLES below minimum");
    end

    // host phases
    typedef enum logic [1:0] {
        PRS_H_INIT = 2'b00,
        PRS_H_PULSE = 2'b01,
        PRS_H_RECOVER = 2'b10,
        PRS_H_READY = 2'b11
    } prs_host_e;
    prs_host_e ph_q;
    logic [23:0] cnt_q;
    logic [23:0] since_fall_q;

    // recovery ends once both select spacings are met
    localparam int REC_CYC = prs_pkg::RESET_HIGH_CYC;
    wire init_over = (cnt_q >= 24'(INIT_CYCLES)); // RULE17
    wire pulse_over = (cnt_q >= 24'(PULSE_CYCLES - 1)); // RULE8
    wire rec_over = (cnt_q >= 24'(REC_CYC - 1)) &&
        (since_fall_q >= 24'(prs_pkg::RESET_LOW_CYC - 1)); // RULE9 RULE10

    // phase sequencer and pin drive
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ph_q <= PRS_H_INIT;
            cnt_q <= 24'h000000;
            since_fall_q <= 24'h000000;
            link.hw_reset_n <= 1'b1;
            link.cs_n <= 1'b1; // RULE2
            link_ready <= 1'b0;
            data_lost <= 1'b1;
            busy <= 1'b1;
        end
        else if (clk_en)
        begin
            cnt_q <= cnt_q + 24'h000001;
            if (since_fall_q != 24'hffffff)
                since_fall_q <= since_fall_q + 24'h000001;
            case (ph_q)
                PRS_H_INIT:
                    // select held high for the whole init wait
                    if (init_over)
                    begin
                        ph_q <= PRS_H_READY; // RULE2 RULE4
                        link_ready <= 1'b1;
                        busy <= 1'b0;
                    end
                PRS_H_PULSE:
                    if (pulse_over)
                    begin
                        ph_q <= PRS_H_RECOVER;
                        link.hw_reset_n <= 1'b1;
                        cnt_q <= 24'h000000;
                    end
                PRS_H_RECOVER:
                    if (rec_over)
                    begin
                        ph_q <= PRS_H_READY;
                        link_ready <= 1'b1;
                        busy <= 1'b0;
                    end
                PRS_H_READY:
                    if (hw_reset_req)
                    begin
                        // reset also covers a too-short supply dip
                        ph_q <= PRS_H_PULSE; // RULE6
                        link.hw_reset_n <= 1'b0;
                        link.cs_n <= 1'b1; // RULE8
                        cnt_q <= 24'h000000;
                        since_fall_q <= 24'h000000;
                        link_ready <= 1'b0;
                        data_lost <= 1'b1; // RULE16
                        busy <= 1'b1;
                    end
                    else
                    begin
                        link.cs_n <= !select_req;
                        if (select_req)
                            data_lost <= 1'b0;
                    end
                default: ph_q <= PRS_H_INIT;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### dv/prs_seq_asserts.sv
// checker for the reset and chip-select spacing on the link pins
// assumes one clock domain; instantiated beside the link in the bench
`timescale 1ns/100ps
`default_nettype none
module prs_seq_asserts #(
    parameter int INIT_CYCLES = prs_pkg::INIT_WAIT_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // link pins
    input wire logic cs_n,
    input wire logic hw_reset_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // cycles since reset release, saturating so it cannot wrap
    int init_cnt_q;
    // cycles since the reset pin was last low; starts high so power-up is clean
    int rise_cnt_q;
    // counters for the long spacing rules
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            init_cnt_q <= 0;
            rise_cnt_q <= 100;
        end
        else
        begin
            if (init_cnt_q < INIT_CYCLES)
                init_cnt_q <= init_cnt_q + 1;
            if (!hw_reset_n)
                rise_cnt_q <= 0;
            else if (rise_cnt_q < 100)
                rise_cnt_q <= rise_cnt_q + 1;
        end
    end
    // pin low for the least pulse, select idle for 200 ns
    sequence s_low8;
        !hw_reset_n [*8];
    endsequence
    sequence s_idle8;
        cs_n [*8];
    endsequence
    property p_pulse_min;
        $fell(hw_reset_n) |-> s_low8;
    endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("reset pulse too short");
    property p_pulse_end;
        $fell(hw_reset_n) |-> ##[8:12] hw_reset_n;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("reset pulse never ends");
    property p_no_sel_low;
        !hw_reset_n |-> cs_n;
    endproperty
    a_no_sel_low: assert property (p_no_sel_low) else $error("select during reset");
    property p_fall_to_sel;
        $fell(hw_reset_n) |-> s_idle8 ##1 s_idle8;
    endproperty
    a_fall_to_sel: assert property (p_fall_to_sel) else $error("select too soon after fall");
    property p_high_to_sel;
        $rose(hw_reset_n) |-> s_idle8;
    endproperty
    a_high_to_sel: assert property (p_high_to_sel) else $error("select too soon after rise");
    property p_sel_spacing;
        $fell(cs_n) |-> rise_cnt_q >= 8;
    endproperty
    a_sel_spacing: assert property (p_sel_spacing) else $error("select spacing short");
    property p_init_idle;
        init_cnt_q < INIT_CYCLES |-> cs_n;
    endproperty
    a_init_idle: assert property (p_init_idle) else $error("select during init wait");
    property p_por_idle;
        $rose(rst_n) |-> cs_n && hw_reset_n;
    endproperty
    a_por_idle: assert property (p_por_idle) else $error("pins not idle at power-up");
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench: host and device ends joined by the link interface
// assumes a 40 MHz clock and a shortened init wait on both ends
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD %0t line %0d", $time, `__LINE__); end end
`define WAITF(c) begin for (int i = 0; i < 200 && (c) !== 1'b1; i++) tick(1); #1; \
    if ((c) !== 1'b1) begin num_errors++; $display("BAD %0t wait timed out", $time); end end
module testbench;
    // short init wait keeps the run brief
    localparam int INIT = 50;
    // row: requests to apply, then state and config expected before reset
    typedef struct packed {logic s; logic d; logic w; logic [15:0] wd; logic [2:0] st;
        logic [15:0] cf;} prs_row_s;
    logic clk_sys = 1'b0;
    logic rst_n, clk_en, supply_ok, supply_above_lockout, sleep_req, dpd_req, cfg_wr;
    logic hw_reset_req, select_req, ready, refresh_active, array_valid, access_violation;
    logic link_ready, data_lost, busy;
    logic [15:0] cfg_wdata, cfg;
    logic [2:0] state;
    logic [prs_pkg::ROW_W-1:0] refresh_row;
    int num_errors = 0;
    int checks = 0;
    prs_row_s rows [3];
    prs_link_if link();
    // 25 ns period
    always #12.5 clk_sys = ~clk_sys;
    prs_host #(.INIT_CYCLES(INIT)) prs_host_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .clk_en(clk_en), .link(link), .hw_reset_req(hw_reset_req), .select_req(select_req),
        .link_ready(link_ready), .data_lost(data_lost), .busy(busy));
    prs_device #(.INIT_CYCLES(INIT)) prs_device_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .clk_en(clk_en), .link(link), .supply_ok(supply_ok),
        .supply_above_lockout(supply_above_lockout), .sleep_req(sleep_req),
        .dpd_req(dpd_req), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .ready(ready),
        .refresh_active(refresh_active), .array_valid(array_valid), .state(state),
        .cfg(cfg), .refresh_row(refresh_row), .access_violation(access_violation));
    prs_seq_asserts #(.INIT_CYCLES(INIT)) prs_seq_asserts_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .cs_n(link.cs_n), .hw_reset_n(link.hw_reset_n));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // report counts and end the run
    task automatic summarize();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one hardware reset; the array side is looked at while the pin is still low
    task automatic hw_reset();
        hw_reset_req <= 1'b1;
        tick(1);
        hw_reset_req <= 1'b0;
        tick(7);
        #1;
        `CHK(link.hw_reset_n, 1'b0)
        `CHK(refresh_active, 1'b0)
        `CHK(array_valid, 1'b0)
        `CHK(refresh_row, prs_pkg::ROW_RESET_VALUE)
        `CHK(state, prs_pkg::PRS_ST_RESET)
        `CHK(busy, 1'b1)
        `WAITF(link_ready)
        tick(2);
        #1;
        `CHK(data_lost, 1'b1)
        `CHK(busy, 1'b0)
    endtask
    // watchdog well beyond the expected few hundred cycles
    initial
    begin
        tick(6000);
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end
    initial
    begin
        rows[0] = '{1'b1, 1'b0, 1'b0, 16'h0000, prs_pkg::PRS_ST_HYBRID_SLEEP,
            prs_pkg::CFG_RESET_VALUE};
        rows[1] = '{1'b0, 1'b1, 1'b0, 16'h0000, prs_pkg::PRS_ST_DEEP_POWER_DOWN,
            prs_pkg::CFG_RESET_VALUE};
        rows[2] = '{1'b0, 1'b0, 1'b1, 16'h1234, prs_pkg::PRS_ST_STANDBY, 16'h1234};
        rst_n = 1'b0;
        clk_en = 1'b1;
        supply_ok = 1'b0;
        supply_above_lockout = 1'b1;
        {sleep_req, dpd_req, cfg_wr, hw_reset_req, select_req} = 5'h00;
        cfg_wdata = 16'h0000;
        tick(10);
        rst_n <= 1'b1;
        tick(20);
        supply_ok <= 1'b1;
        #1;
        `CHK(ready, 1'b0)
        tick(40);
        #1;
        `CHK(ready, 1'b0)
        `WAITF(ready)
        `CHK(state, prs_pkg::PRS_ST_STANDBY)
        `CHK(refresh_active, 1'b1)
        `CHK(array_valid, 1'b1)
        `WAITF(link_ready)
        `CHK(link.cs_n, 1'b1)
        $display("test power-up done");
        foreach (rows[k])
        begin
            tick(1);
            sleep_req <= rows[k].s;
            dpd_req <= rows[k].d;
            cfg_wr <= rows[k].w;
            cfg_wdata <= rows[k].wd;
            tick(1);
            {sleep_req, dpd_req, cfg_wr} <= 3'h0;
            tick(6);
            #1;
            `CHK(state, rows[k].st)
            `CHK(cfg, rows[k].cf)
            tick(1);
            hw_reset();
            `CHK(state, prs_pkg::PRS_ST_STANDBY)
            `CHK(cfg, prs_pkg::CFG_RESET_VALUE)
            `CHK(refresh_active, 1'b1)
            `CHK((refresh_row != prs_pkg::ROW_RESET_VALUE), 1'b1)
            tick(1);
            select_req <= 1'b1;
            `WAITF(link.cs_n === 1'b0)
            tick(2);
            #1;
            `CHK(data_lost, 1'b0)
            `CHK(access_violation, 1'b0)
            tick(1);
            select_req <= 1'b0;
            $display("test row %0d done", k);
        end
        // frozen clock enable must not let a reset request through
        tick(1);
        clk_en <= 1'b0;
        hw_reset_req <= 1'b1;
        tick(4);
        #1;
        `CHK(link.hw_reset_n, 1'b1)
        tick(1);
        hw_reset_req <= 1'b0;
        clk_en <= 1'b1;
        $display("test freeze done");
        // supply dip below lockout, recovered by a hardware reset
        tick(2);
        supply_above_lockout <= 1'b0;
        tick(6);
        #1;
        `CHK(ready, 1'b0)
        // supply returns while the reset pin is low: init must wait for its release
        tick(1);
        fork
            hw_reset();
            begin
                tick(3);
                supply_above_lockout <= 1'b1;
            end
        join
        `CHK(state, prs_pkg::PRS_ST_INIT)
        `WAITF(ready)
        `CHK(state, prs_pkg::PRS_ST_STANDBY)
        `CHK(array_valid, 1'b1)
        $display("test dip done");
        summarize();
    end
endmodule
`default_nettype wire
